/* inc/ttic_pkg.sv */
// constants for the timer and time base interrupt controller
package ttic_pkg;
    // register byte addresses on the register bus
    localparam logic [3:0] ADDR_MAIN = 4'h0;
    localparam logic [3:0] ADDR_TB   = 4'h4;
    // main_interrupt_control field positions
    localparam int MAIN_TMR1_FLAG = 6;
    localparam int MAIN_TMR0_FLAG = 5;
    localparam int MAIN_EXTF      = 4;
    localparam int MAIN_TMR1_EN   = 3;
    localparam int MAIN_TMR0_EN   = 2;
    localparam int MAIN_EXTE      = 1;
    localparam int MAIN_GLOBAL_EN = 0;
    // time_base_interrupt_control field positions
    localparam int TB_FLAG   = 4;
    localparam int TB_EN     = 0;
    // reset values
    localparam logic [3:0] FLAG_RST = 4'h0;
    localparam logic [3:0] EN_RST   = 4'h0;
    localparam logic       GLOBAL_EN_RST = 1'b0;
    // source index, in priority order
    localparam int SRC_EXT = 0;
    localparam int SRC_T0  = 1;
    localparam int SRC_T1  = 2;
    localparam int SRC_TB  = 3;
    localparam int NSRC    = 4;
    // vectors per source
    localparam logic [7:0] VEC_EXT = 8'h04;
    localparam logic [7:0] VEC_T0  = 8'h08;
    localparam logic [7:0] VEC_T1  = 8'h0c;
    localparam logic [7:0] VEC_TB  = 8'h10;
    // timing: clock period, instruction cycle, vector latency
    localparam int CLK_NS        = 50;
    localparam int INST_CLKS     = 4;
    localparam int INST_NS       = CLK_NS * INST_CLKS;
    localparam logic [1:0] PH_LAST = 2'(INST_CLKS - 1);
    localparam int LAT_NORM_INST = 2;
    localparam int LAT_WAKE_INST = 3;
    localparam logic [1:0] WAIT_NORM = 2'(LAT_NORM_INST - 1);
    localparam logic [1:0] WAIT_WAKE = 2'(LAT_WAKE_INST - 1);
    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [0:0] {TTIC_IDLE, TTIC_WAIT} ttic_state_t;
endpackage : ttic_pkg

/* core/ttic_top.sv */
// timer and time base interrupt controller with register bus slave
// Behaviour
// - time base register bits 7..5 and 3..1 read as zero
// - time base register bit 4 is the time base request flag, reset 0
// - time base register bit 0 is the time base enable, reset 0
// - main register flags: timer1 bit 6, timer0 bit 5, external bit 4
// - main register enables: timer1 bit 3, timer0 bit 2, external bit 1; bit 7 zero
// - main register bit 0 is global enable; clear blocks all servicing
// - timer interrupt needs global enable and its own enable
// - timer overflow sets that timer's request flag
// - enabled timer request with stack room calls the timer's vector
// - servicing a timer clears its flag and the global enable
// - time base interrupt needs global enable and time base enable
// - time base overflow sets the time base request flag
// - enabled time base request with stack room calls its vector
// - servicing time base clears its flag and the global enable
// - flags stay set until serviced or cleared; enables never discard them
// - every source can wake the processor from idle or sleep
// - interrupt entry pushes only the program counter
// - priority external 04h, timer0 08h, timer1 0ch, time base 10h
// - vector call 2 or 3 instruction cycles after request, 3 on wake
// - no request acknowledged while stack is full
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module ttic_top (
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_rst_n,
    input  wire logic                 i_awvalid,
    output logic                      o_awready,
    input  wire logic [3:0]           i_awaddr,
    input  wire logic                 i_wvalid,
    output logic                      o_wready,
    input  wire logic [31:0]          i_wdata,
    input  wire logic [3:0]           i_wstrb,
    output logic                      o_bvalid,
    input  wire logic                 i_bready,
    output logic [1:0]                o_bresp,
    input  wire logic                 i_arvalid,
    output logic                      o_arready,
    input  wire logic [3:0]           i_araddr,
    output logic                      o_rvalid,
    input  wire logic                 i_rready,
    output logic [31:0]               o_rdata,
    output logic [1:0]                o_rresp,
    input  wire logic                 i_ext_req,
    input  wire logic                 i_tmr0_ovf,
    input  wire logic                 i_tmr1_ovf,
    input  wire logic                 i_tb_ovf,
    input  wire logic                 i_stack_full,
    input  wire logic                 i_low_power,
    output logic                      o_call,
    output logic                      o_push_pc,
    output logic [7:0]                o_vector,
    output logic                      o_wake
);
    import ttic_pkg::*;

    logic [NSRC-1:0] flag;
    logic [NSRC-1:0] en;
    logic            global_irq_enable;
    logic [NSRC-1:0] next_flag;
    logic [NSRC-1:0] hw_set;
    logic [NSRC-1:0] cand;
    logic [NSRC-1:0] win;
    logic [7:0]      win_vec;
    logic            fire;
    logic [1:0]      phase;
    logic            boundary;
    logic [1:0]      wcnt;
    ttic_state_t     state;

    // bus state
    logic            aw_got;
    logic            w_got;
    logic [3:0]      waddr;
    logic [7:0]      wbyte;
    logic            wbyte_en;
    logic            do_wr;
    logic            wr_main;
    logic            wr_tb;
    logic [7:0]      main_rd;
    logic [7:0]      tb_rd;

    // ---------------- register bus slave ----------------
    assign do_wr   = aw_got && w_got && !o_bvalid;
    assign wr_main = do_wr && wbyte_en && (waddr == ADDR_MAIN);
    assign wr_tb   = do_wr && wbyte_en && (waddr == ADDR_TB);

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            aw_got <= 1'b0;
            waddr  <= 4'h0;
        end else if (i_awvalid && o_awready) begin
            aw_got <= 1'b1;
            waddr  <= i_awaddr;
        end else if (do_wr) begin
            aw_got <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            w_got    <= 1'b0;
            wbyte    <= 8'h00;
            wbyte_en <= 1'b0;
        end else if (i_wvalid && o_wready) begin
            w_got    <= 1'b1;
            wbyte    <= i_wdata[7:0];
            wbyte_en <= i_wstrb[0];
        end else if (do_wr) begin
            w_got <= 1'b0;
        end
    end

    // one write in flight; ready drops while a half is held or a response waits
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_awready <= 1'b0;
            o_wready  <= 1'b0;
        end else begin
            o_awready <= !aw_got && !(i_awvalid && o_awready) && !o_bvalid;
            o_wready  <= !w_got && !(i_wvalid && o_wready) && !o_bvalid;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_bvalid <= 1'b0;
            o_bresp  <= RESP_OKAY;
        end else if (do_wr) begin
            o_bvalid <= 1'b1;
            o_bresp  <= (waddr == ADDR_MAIN || waddr == ADDR_TB) ? RESP_OKAY : RESP_SLVERR;
        end else if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    // read images; unimplemented bits tie to zero
    always_comb begin
        main_rd                 = 8'h00;
        main_rd[MAIN_TMR1_FLAG] = flag[SRC_T1];
        main_rd[MAIN_TMR0_FLAG] = flag[SRC_T0];
        main_rd[MAIN_EXTF]      = flag[SRC_EXT];
        main_rd[MAIN_TMR1_EN]   = en[SRC_T1];
        main_rd[MAIN_TMR0_EN]   = en[SRC_T0];
        main_rd[MAIN_EXTE]      = en[SRC_EXT];
        main_rd[MAIN_GLOBAL_EN] = global_irq_enable;
        tb_rd              = 8'h00;
        tb_rd[TB_FLAG]     = flag[SRC_TB];
        tb_rd[TB_EN]       = en[SRC_TB];
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_arready <= 1'b0;
        end else begin
            o_arready <= !(i_arvalid && o_arready) && !o_rvalid;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_rvalid <= 1'b0;
            o_rdata  <= 32'h0000_0000;
            o_rresp  <= RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            o_rvalid <= 1'b1;
            unique case (i_araddr)
                ADDR_MAIN: begin
                    o_rdata <= {24'h00_0000, main_rd};
                    o_rresp <= RESP_OKAY;
                end
                ADDR_TB: begin
                    o_rdata <= {24'h00_0000, tb_rd};
                    o_rresp <= RESP_OKAY;
                end
                default: begin
                    o_rdata <= 32'h0000_0000;
                    o_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
        end
    end

    // ---------------- request flags and enables ----------------
    assign hw_set = {i_tb_ovf, i_tmr1_ovf, i_tmr0_ovf, i_ext_req};

    // hardware set wins over software clear and over the service clear
    always_comb begin
        next_flag = flag;
        if (wr_main) begin
            next_flag[SRC_T1]  = wbyte[MAIN_TMR1_FLAG];
            next_flag[SRC_T0]  = wbyte[MAIN_TMR0_FLAG];
            next_flag[SRC_EXT] = wbyte[MAIN_EXTF];
        end
        if (wr_tb) begin
            next_flag[SRC_TB] = wbyte[TB_FLAG];
        end
        if (fire) begin
            next_flag = next_flag & ~win;
        end
        next_flag = next_flag | hw_set;
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            flag <= FLAG_RST;
        end else begin
            flag <= next_flag;
        end
    end

    // enables gate servicing and wake; they never touch a pending flag
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            en <= EN_RST;
        end else begin
            if (wr_main) begin
                en[SRC_T1]  <= wbyte[MAIN_TMR1_EN];
                en[SRC_T0]  <= wbyte[MAIN_TMR0_EN];
                en[SRC_EXT] <= wbyte[MAIN_EXTE];
            end
            if (wr_tb) begin
                en[SRC_TB] <= wbyte[TB_EN];
            end
        end
    end

    // service clear is applied after a software write in the same cycle
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            global_irq_enable <= GLOBAL_EN_RST;
        end else if (fire) begin
            global_irq_enable <= 1'b0;
        end else if (wr_main) begin
            global_irq_enable <= wbyte[MAIN_GLOBAL_EN];
        end
    end

    // ---------------- arbitration ----------------
    assign cand = (i_stack_full || !global_irq_enable) ? '0
                : (flag & en);

    always_comb begin
        win     = '0;
        win_vec = VEC_EXT;
        if (cand[SRC_EXT]) begin
            win[SRC_EXT] = 1'b1;
            win_vec      = VEC_EXT;
        end else if (cand[SRC_T0]) begin
            win[SRC_T0] = 1'b1;
            win_vec     = VEC_T0;
        end else if (cand[SRC_T1]) begin
            win[SRC_T1] = 1'b1;
            win_vec     = VEC_T1;
        end else if (cand[SRC_TB]) begin
            win[SRC_TB] = 1'b1;
            win_vec     = VEC_TB;
        end
    end

    // ---------------- instruction cycle timing ----------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
        end
    end

    assign boundary = (phase == PH_LAST);
    // winner is picked again at the call so a later, higher source is not starved
    assign fire = (state == TTIC_WAIT) && boundary && (wcnt == 2'h1) && (|cand);

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            state <= TTIC_IDLE;
            wcnt  <= 2'h0;
        end else begin
            unique case (state)
                TTIC_IDLE: begin
                    if (boundary && (|cand)) begin
                        state <= TTIC_WAIT;
                        wcnt  <= i_low_power ? WAIT_WAKE : WAIT_NORM;
                    end
                end
                TTIC_WAIT: begin
                    if (boundary) begin
                        if (wcnt == 2'h1) begin
                            state <= TTIC_IDLE;
                        end
                        wcnt <= wcnt - 2'h1;
                    end
                end
            endcase
        end
    end

    // call and push are one pulse; no accumulator or status save exists
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_call    <= 1'b0;
            o_push_pc <= 1'b0;
            o_vector  <= 8'h00;
        end else begin
            o_call    <= fire;
            o_push_pc <= fire;
            if (fire) begin
                o_vector <= win_vec;
            end
        end
    end

    // wake ignores the global enable so a halted core can poll flags
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_wake <= 1'b0;
        end else begin
            o_wake <= |(next_flag & en);
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    tb_reserved_a: assert property (o_rvalid
        && $past(i_araddr == ADDR_TB && i_arvalid && o_arready)
        |-> (o_rdata[7:5] == 3'h0 && o_rdata[3:1] == 3'h0))
        else $error("reserved time base bits read nonzero");
    main_reserved_a: assert property (o_rvalid && $past(i_araddr == ADDR_MAIN
        && i_arvalid && o_arready) |-> o_rdata[7] == 1'b0)
        else $error("main register bit 7 read nonzero");
    ovf_sets_a: assert property (i_tmr0_ovf |=> flag[SRC_T0])
        else $error("timer0 overflow did not set flag");
    tb_sets_a: assert property (i_tb_ovf |=> flag[SRC_TB])
        else $error("time base overflow did not set flag");
    global_block_a: assert property (!global_irq_enable |-> !fire)
        else $error("service taken with global enable clear");
    stack_block_a: assert property (i_stack_full |=> !o_call)
        else $error("call issued while stack full");
    call_clears_a: assert property (o_call |-> !global_irq_enable)
        else $error("global enable not cleared on service");
    flag_hold_a: assert property (flag[SRC_T1] && !i_tmr1_ovf && !fire && !wr_main
        |=> flag[SRC_T1])
        else $error("timer1 flag lost without service or write");
    vec_prio_a: assert property (fire && cand[SRC_EXT] |=> o_vector == VEC_EXT)
        else $error("external source not given priority");
    tb_vec_a: assert property (fire && cand == 4'h8 |=> o_vector == VEC_TB)
        else $error("time base vector wrong");
    // wait starts one clock after a boundary, so the next boundary is three clocks on
    lat_norm_a: assert property ($rose(state == TTIC_WAIT) && wcnt == WAIT_NORM
        && cand == $past(cand) |-> ##3 (fire || !(|cand)))
        else $error("normal vector latency wrong");
    lat_wake_a: assert property ($rose(state == TTIC_WAIT) && wcnt == WAIT_WAKE
        |-> ##7 (fire || !(|cand)))
        else $error("wake vector latency wrong");
    push_only_a: assert property (o_push_pc == o_call)
        else $error("push not paired with call");
    // a write or a service may drop the last pending flag in the same cycle
    wake_a: assert property ((flag & en) != 4'h0 && !fire && !wr_main && !wr_tb
        |=> o_wake)
        else $error("pending enabled source did not wake");
    sw_flag_a: assert property (wr_tb && wbyte[TB_FLAG] && !fire |=> flag[SRC_TB])
        else $error("software write did not raise time base flag");
    tmr1_gate_a: assert property (o_call && o_vector == VEC_T1
        |-> $past(en[SRC_T1] && global_irq_enable))
        else $error("timer1 serviced while not enabled");
    tb_gate_a: assert property (o_call && o_vector == VEC_TB
        |-> $past(en[SRC_TB] && global_irq_enable))
        else $error("time base serviced while not enabled");

    call_c: cover property (o_call && o_vector == VEC_T0);
    wake_call_c: cover property (i_low_power && o_wake ##[1:20] o_call);
    sw_raise_c: cover property (wr_tb && wbyte[TB_FLAG] ##[1:20] o_call);
    block_c: cover property (i_stack_full && (flag & en) != 4'h0 && global_irq_enable);
endmodule : ttic_top

/* sim/ttic_core_model.sv */
// stand-in for the processor core and the timer and time base peripherals
`timescale 1ns/1ps
module ttic_core_model (
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_n,
    input  wire logic [3:0] i_fire,
    input  wire logic       i_full,
    input  wire logic       i_sleep,
    input  wire logic       i_call,
    input  wire logic       i_push_pc,
    input  wire logic [7:0] i_vector,
    output logic      [3:0] o_pulse,
    output logic            o_stack_full,
    output logic            o_low_power,
    output int              o_ncalls,
    output logic      [7:0] o_last_vec,
    output logic            o_push_bad
);
    // one held cycle of a fire bit becomes one overflow pulse
    always_ff @(posedge i_ref_clk) begin
        o_pulse      <= i_rst_n ? i_fire : 4'h0;
        o_stack_full <= i_full;
        o_low_power  <= i_sleep;
    end
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_ncalls   <= 0;
            o_last_vec <= 8'h00;
            o_push_bad <= 1'b0;
        end else begin
            if (i_call === 1'b1) begin
                o_ncalls   <= o_ncalls + 1;
                o_last_vec <= i_vector;
            end
            // the core pushes the program counter only, exactly with the call
            if (i_push_pc !== i_call) o_push_bad <= 1'b1;
        end
    end
endmodule : ttic_core_model

/* sim/testbench.sv */
// self-checking bench for the timer and time base interrupt controller
`timescale 1ns/1ps
module testbench;
    import ttic_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0, fire = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        full = 1'b0, sleep = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, call, push, wake, push_bad;
    logic        stack_full, low_power;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [7:0]  vector, last_vec;
    logic [3:0]  pulse;
    int          ncalls, n_errors = 0, checks = 0, cyc = 0;

    ttic_top i_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_awvalid(awvalid), .o_awready(awready),
        .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
        .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
        .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid),
        .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .i_ext_req(pulse[0]),
        .i_tmr0_ovf(pulse[1]), .i_tmr1_ovf(pulse[2]), .i_tb_ovf(pulse[3]),
        .i_stack_full(stack_full), .i_low_power(low_power), .o_call(call),
        .o_push_pc(push), .o_vector(vector), .o_wake(wake));
    ttic_core_model i_core (.i_ref_clk(clk), .i_rst_n(rst_n), .i_fire(fire), .i_full(full),
        .i_sleep(sleep), .i_call(call), .i_push_pc(push), .i_vector(vector),
        .o_pulse(pulse), .o_stack_full(stack_full), .o_low_power(low_power),
        .o_ncalls(ncalls), .o_last_vec(last_vec), .o_push_bad(push_bad));

    always #25 clk = ~clk;

    task automatic close_out();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : close_out

    // whole run needs a few hundred cycles; a hang ends here
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            close_out();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
        logic ad, wd, ok;
        ad = 1'b0;
        wd = 1'b0;
        ok = 1'b0;
        awaddr  <= a;
        wdata   <= {24'h0, d};
        wstrb   <= 4'h1;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        // readies are registered, so the mid-cycle value is the one the edge sees
        while (!(ad && wd)) begin
            @(negedge clk);
            if (awready && awvalid) ad = 1'b1;
            if (wready && wvalid) wd = 1'b1;
            @(posedge clk);
            if (ad) awvalid <= 1'b0;
            if (wd) wvalid <= 1'b0;
        end
        bready <= 1'b1;
        while (!ok) begin
            @(negedge clk);
            ok = bvalid;
            if (ok) chk($sformatf("bresp@%h", a), {30'h0, er}, {30'h0, bresp});
            @(posedge clk);
        end
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input logic [1:0] er);
        logic ok;
        ok = 1'b0;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (!ok) begin
            @(negedge clk);
            ok = arready;
            @(posedge clk);
        end
        arvalid <= 1'b0;
        ok = 1'b0;
        while (!ok) begin
            @(negedge clk);
            ok = rvalid;
            if (ok) chk($sformatf("rdata@%h", a), {24'h0, exp}, rdata);
            if (ok) chk($sformatf("rresp@%h", a), {30'h0, er}, {30'h0, rresp});
            @(posedge clk);
        end
        rready <= 1'b0;
    endtask : rd

    task automatic pulse_src(input logic [3:0] bits);
        fire <= bits;
        @(posedge clk);
        fire <= 4'h0;
        repeat (2) @(posedge clk);
    endtask : pulse_src

    task automatic no_call(input int n);
        int start;
        start = ncalls;
        repeat (n) @(posedge clk);
        @(negedge clk);
        chk("call count", start, ncalls);
        @(posedge clk);
    endtask : no_call

    task automatic wait_call(input int max, input logic [7:0] vec);
        int start, n;
        start = ncalls;
        n = 0;
        while (ncalls == start && n < max) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        chk("call count", start + 1, ncalls);
        chk("vector", {24'h0, vec}, {24'h0, last_vec});
    endtask : wait_call

    task automatic sc_regs();
        rd(ADDR_MAIN, 8'h00, RESP_OKAY);
        rd(ADDR_TB, 8'h00, RESP_OKAY);
        rd(4'h8, 8'h00, RESP_SLVERR);
        wr(4'h8, 8'hff, RESP_SLVERR);
        wr(ADDR_TB, 8'hff, RESP_OKAY);
        rd(ADDR_TB, 8'h11, RESP_OKAY);
        wr(ADDR_MAIN, 8'hfe, RESP_OKAY);
        rd(ADDR_MAIN, 8'h7e, RESP_OKAY);
        no_call(24);
        wr(ADDR_MAIN, 8'h00, RESP_OKAY);
        wr(ADDR_TB, 8'h00, RESP_OKAY);
        rd(ADDR_MAIN, 8'h00, RESP_OKAY);
    endtask : sc_regs

    task automatic sc_priority();
        logic [7:0] exp;
        logic [7:0] vecs [3];
        vecs = '{VEC_EXT, VEC_T0, VEC_T1};
        pulse_src(4'hf);
        rd(ADDR_MAIN, 8'h70, RESP_OKAY);
        rd(ADDR_TB, 8'h10, RESP_OKAY);
        wr(ADDR_MAIN, 8'h7e, RESP_OKAY);
        wr(ADDR_TB, 8'h11, RESP_OKAY);
        no_call(24);
        exp = 8'h7e;
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_MAIN, exp | 8'h01, RESP_OKAY);
            wait_call(16, vecs[i]);
            exp = exp & ~(8'h10 << i);
            rd(ADDR_MAIN, exp, RESP_OKAY);
        end
        wr(ADDR_MAIN, exp | 8'h01, RESP_OKAY);
        wait_call(16, VEC_TB);
        rd(ADDR_TB, 8'h01, RESP_OKAY);
        rd(ADDR_MAIN, 8'h0e, RESP_OKAY);
    endtask : sc_priority

    task automatic sc_stack();
        full <= 1'b1;
        pulse_src(4'h2);
        wr(ADDR_MAIN, 8'h25, RESP_OKAY);
        no_call(24);
        rd(ADDR_MAIN, 8'h25, RESP_OKAY);
        full <= 1'b0;
        wait_call(24, VEC_T0);
        rd(ADDR_MAIN, 8'h04, RESP_OKAY);
    endtask : sc_stack

    task automatic sc_wake();
        sleep <= 1'b1;
        pulse_src(4'h8);
        wr(ADDR_TB, 8'h11, RESP_OKAY);
        @(negedge clk);
        chk("wake", 32'h1, {31'h0, wake});
        @(posedge clk);
        wr(ADDR_MAIN, 8'h01, RESP_OKAY);
        wait_call(24, VEC_TB);
        sleep <= 1'b0;
        @(negedge clk);
        chk("wake", 32'h0, {31'h0, wake});
        chk("push only with call", 32'h0, {31'h0, push_bad});
        @(posedge clk);
    endtask : sc_wake

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        sc_regs();
        sc_priority();
        sc_stack();
        sc_wake();
        close_out();
    end
endmodule : testbench
